/* stc_pkg.sv */
// Package: constants and types for the cpu logic self-test controller
package stc_pkg;

	// ==========================================================
	// Register map (byte addresses on the plain register port)
	// ==========================================================
	localparam logic [31:0] STC_DIVIDE_RATIO_FIELD_ADDR = 32'hffffe108;
	localparam logic [31:0] STC_CTRL_ADDR = 32'hffffe100;
	localparam logic [31:0] STC_INTCNT_ADDR = 32'hffffe104;
	localparam logic [31:0] STC_TMO_ADDR = 32'hffffe10c;
	localparam logic [31:0] STC_STAT_ADDR = 32'hffffe110;
	localparam logic [31:0] STC_FAILINT_ADDR = 32'hffffe114;
	localparam logic [31:0] STC_IMASK_ADDR = 32'hffffe118;
	localparam logic [31:0] STC_CURINT_ADDR = 32'hffffe11c;

	// ==========================================================
	// Field positions
	// ==========================================================
	localparam int STC_CTRL_RUN_BIT = 0;
	localparam int STC_CTRL_RESTART_BIT = 1;
	localparam int STC_CTRL_CORE_BIT = 2;
	localparam int STC_CTRL_FULL_BIT = 3;
	localparam int STC_ST_DONE_BIT = 0;
	localparam int STC_ST_FAIL_BIT = 1;
	localparam int STC_ST_TMO_BIT = 2;
	localparam int STC_ST_RSTCAUSE_BIT = 5;
	localparam int STC_DIV_LSB = 0;
	localparam int STC_DIV_W = 3;
	localparam int STC_ST_W = 6;

	// ==========================================================
	// Sizes, reset values, timing
	// ==========================================================
	localparam int STC_INT_W = 5;
	localparam logic [STC_INT_W-1:0] STC_MAX_INTERVALS = 5'h18;
	localparam int STC_CYC_PER_INTERVAL = 1365;
	localparam int STC_CYC_W = 11;
	localparam int STC_TMO_W = 32;
	localparam logic [STC_DIV_W-1:0] STC_DIV_RESET = 3'h0;
	localparam logic [STC_INT_W-1:0] STC_INTCNT_RESET = 5'h01;
	localparam logic [STC_TMO_W-1:0] STC_TMO_RESET = 32'hffffffff;
	localparam int STC_RST_PULSE_CYC = 32;

	typedef enum logic [2:0] {
		STC_IDLE,
		STC_RUN,
		STC_CHECK,
		STC_RESET
	} stc_state_t;

endpackage

/* stc_divide_ratio_field.sv */
// Self-test clock enable generator: divides core clock by 1..8
`timescale 1ns/1ps
module stc_divide_ratio_field
	import stc_pkg::*;
(
	// Clock, reset, enable
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	// Control
	input wire logic active_in,
	input wire logic [STC_DIV_W-1:0] divide_ratio_field_in,
	// Tick for core and delayed core clock alike
	output logic tick_out
);
	logic [STC_DIV_W-1:0] cnt_q, cnt_d;

	// Field value n divides by n+1, so range is 1 to 8
	always_comb begin
		cnt_d = cnt_q;
		if (!active_in) begin
			cnt_d = '0;
		end else if (cnt_q >= divide_ratio_field_in) begin
			cnt_d = '0;
		end else begin
			cnt_d = cnt_q + 3'h1;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			cnt_q <= '0;
		end else if (clk_en_in) begin
			cnt_q <= cnt_d;
		end
	end

	assign tick_out = active_in && (cnt_q >= divide_ratio_field_in);
endmodule // stc_divide_ratio_field

/* stc_interval.sv */
// Interval cycle counter: one fixed-length test interval per start
`timescale 1ns/1ps
module stc_interval
	import stc_pkg::*;
(
	// Clock, reset, enable
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	// Control
	input wire logic start_in,
	input wire logic tick_in,
	// Status
	output logic busy_out,
	output logic done_out
);
	logic [STC_CYC_W-1:0] cnt_q, cnt_d;
	logic busy_q, busy_d;
	localparam logic [STC_CYC_W-1:0] LAST = STC_CYC_W'(STC_CYC_PER_INTERVAL - 1);

	always_comb begin
		cnt_d = cnt_q;
		busy_d = busy_q;
		done_out = 1'b0;
		if (start_in) begin
			cnt_d = '0;
			busy_d = 1'b1;
		end else if (busy_q && tick_in) begin
			if (cnt_q == LAST) begin
				busy_d = 1'b0;
				done_out = 1'b1;
			end else begin
				cnt_d = cnt_q + 11'h001;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			cnt_q <= '0;
			busy_q <= 1'b0;
		end else if (clk_en_in) begin
			cnt_q <= cnt_d;
			busy_q <= busy_d;
		end
	end

	assign busy_out = busy_q;
endmodule // stc_interval

/* stc_ctrl.sv */
// Top: cpu logic self-test controller with registers and run sequencer
//
// Operation
// - Drive logic self-test engine on one core per run, picked by the core select bit
// - Test split into independent pass/fail intervals
// - Run all intervals or programmed count
// - Resume after last interval or restart
// - Isolate core under test during run
// - Record failing interval number for software
// - Programmable timeout bounds run duration
// - Run ends with processor reset, status readable
// - Test clock divided via divider register
// - Each interval takes 1365 test clocks
// - Self-test reset flagged in status bit 5
// - Core clocks divided alike, ratio 1 to 8
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module stc_ctrl
	import stc_pkg::*;
(
	// Clock, reset, enable
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	// Register port
	input wire logic [31:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// Self-test engine (pattern source, response checker)
	output logic engine_start_out,
	output logic engine_tick_out,
	output logic [STC_INT_W-1:0] engine_interval_out,
	output logic engine_core_sel_out,
	input wire logic engine_fail_in,
	// Core isolation and reset
	output logic [1:0] core_isolate_out,
	output logic cpu_reset_out,
	// Interrupt
	output logic irq_out
);
	// ==========================================================
	// Registers
	// ==========================================================
	stc_state_t state_q, state_d;
	logic [STC_DIV_W-1:0] div_q, div_d;
	logic [STC_INT_W-1:0] intcnt_q, intcnt_d;
	logic [STC_TMO_W-1:0] tmo_q, tmo_d;
	logic [STC_TMO_W-1:0] tmo_cnt_q, tmo_cnt_d;
	logic restart_q, restart_d;
	logic core_q, core_d;
	logic full_q, full_d;
	logic [STC_INT_W-1:0] next_int_q, next_int_d;
	logic [STC_INT_W-1:0] run_left_q, run_left_d;
	logic [STC_INT_W-1:0] fail_int_q, fail_int_d;
	logic [STC_ST_W-1:0] stat_q, stat_d;
	logic [STC_ST_W-1:0] mask_q, mask_d;
	logic [5:0] rst_cnt_q, rst_cnt_d;
	logic [31:0] rdata_q, rdata_d;
	logic fail_seen_q, fail_seen_d;

	logic tick;
	logic iv_start;
	logic iv_busy;
	logic iv_done;
	logic run_go;
	logic [STC_ST_W-1:0] ev_set;
	logic [STC_ST_W-1:0] wr_clr;

	// ==========================================================
	// Test clock divider and interval counter
	// ==========================================================
	stc_divide_ratio_field u_div (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.clk_en_in(clk_en_in),
		.active_in(state_q == STC_RUN),
		.divide_ratio_field_in(div_q),
		.tick_out(tick)
	);

	stc_interval u_iv (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.clk_en_in(clk_en_in),
		.start_in(iv_start),
		.tick_in(tick),
		.busy_out(iv_busy),
		.done_out(iv_done)
	);

	assign run_go = reg_wr_in && (reg_addr_in == STC_CTRL_ADDR) &&
		reg_wdata_in[STC_CTRL_RUN_BIT];

	// ==========================================================
	// Run sequencer
	// ==========================================================
	always_comb begin
		state_d = state_q;
		next_int_d = next_int_q;
		run_left_d = run_left_q;
		fail_int_d = fail_int_q;
		tmo_cnt_d = tmo_cnt_q;
		rst_cnt_d = rst_cnt_q;
		fail_seen_d = fail_seen_q;
		iv_start = 1'b0;
		ev_set = '0;
		unique case (state_q)
			STC_IDLE: begin
				if (run_go) begin
					state_d = STC_RUN;
					tmo_cnt_d = tmo_q;
					fail_seen_d = 1'b0;
					iv_start = 1'b1;
					if (reg_wdata_in[STC_CTRL_RESTART_BIT] || next_int_q >= STC_MAX_INTERVALS) begin
						next_int_d = '0;
					end
					if (reg_wdata_in[STC_CTRL_FULL_BIT]) begin
						run_left_d = STC_MAX_INTERVALS;
					end else begin
						run_left_d = (intcnt_q == '0) ? 5'h01 : intcnt_q;
					end
				end
			end
			STC_RUN: begin
				if (tick && engine_fail_in) begin
					fail_seen_d = 1'b1;
				end
				if (tmo_cnt_q == '0) begin
					ev_set[STC_ST_TMO_BIT] = 1'b1;
					ev_set[STC_ST_FAIL_BIT] = 1'b1;
					fail_int_d = next_int_q;
					state_d = STC_RESET;
				end else begin
					tmo_cnt_d = tmo_cnt_q - 32'h1;
					if (iv_done) begin
						state_d = STC_CHECK;
					end
				end
			end
			STC_CHECK: begin
				// Each interval judged on its own; stop at first failure
				if (fail_seen_q || engine_fail_in) begin
					ev_set[STC_ST_FAIL_BIT] = 1'b1;
					fail_int_d = next_int_q;
					next_int_d = next_int_q + 5'h01;
					state_d = STC_RESET;
				end else begin
					next_int_d = next_int_q + 5'h01;
					run_left_d = run_left_q - 5'h01;
					if (run_left_q == 5'h01 || next_int_q + 5'h01 >= STC_MAX_INTERVALS) begin
						state_d = STC_RESET;
					end else begin
						iv_start = 1'b1;
						fail_seen_d = 1'b0;
						state_d = STC_RUN;
					end
				end
				if (tmo_cnt_q != '0) begin
					tmo_cnt_d = tmo_cnt_q - 32'h1;
				end
			end
			STC_RESET: begin
				// Hold the reset long enough for the core to see it
				if (rst_cnt_q == 6'(STC_RST_PULSE_CYC - 1)) begin
					rst_cnt_d = '0;
					ev_set[STC_ST_DONE_BIT] = 1'b1;
					ev_set[STC_ST_RSTCAUSE_BIT] = 1'b1;
					state_d = STC_IDLE;
				end else begin
					rst_cnt_d = rst_cnt_q + 6'h01;
				end
			end
			default: state_d = STC_IDLE;
		endcase
	end

	// ==========================================================
	// Register writes and reads
	// ==========================================================
	always_comb begin
		div_d = div_q;
		intcnt_d = intcnt_q;
		tmo_d = tmo_q;
		restart_d = restart_q;
		core_d = core_q;
		full_d = full_q;
		mask_d = mask_q;
		wr_clr = '0;
		rdata_d = '0;
		if (reg_wr_in) begin
			case (reg_addr_in)
				STC_DIVIDE_RATIO_FIELD_ADDR: div_d = reg_wdata_in[STC_DIV_LSB +: STC_DIV_W];
				STC_INTCNT_ADDR: intcnt_d = reg_wdata_in[STC_INT_W-1:0];
				STC_TMO_ADDR: tmo_d = reg_wdata_in;
				STC_CTRL_ADDR: begin
					restart_d = reg_wdata_in[STC_CTRL_RESTART_BIT];
					core_d = reg_wdata_in[STC_CTRL_CORE_BIT];
					full_d = reg_wdata_in[STC_CTRL_FULL_BIT];
				end
				STC_STAT_ADDR: wr_clr = reg_wdata_in[STC_ST_W-1:0];
				STC_IMASK_ADDR: mask_d = reg_wdata_in[STC_ST_W-1:0];
				default: ;
			endcase
		end
		if (reg_rd_in) begin
			case (reg_addr_in)
				STC_DIVIDE_RATIO_FIELD_ADDR: rdata_d = {29'h0, div_q};
				STC_INTCNT_ADDR: rdata_d = {27'h0, intcnt_q};
				STC_TMO_ADDR: rdata_d = tmo_q;
				STC_CTRL_ADDR: rdata_d = {28'h0, full_q, core_q, restart_q,
					state_q != STC_IDLE};
				STC_STAT_ADDR: rdata_d = {26'h0, stat_q};
				STC_FAILINT_ADDR: rdata_d = {27'h0, fail_int_q};
				STC_IMASK_ADDR: rdata_d = {26'h0, mask_q};
				STC_CURINT_ADDR: rdata_d = {27'h0, next_int_q};
				default: rdata_d = '0;
			endcase
		end
		// Set wins over a write-one clear in the same cycle
		stat_d = (stat_q & ~wr_clr) | ev_set;
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			state_q <= STC_IDLE;
			div_q <= STC_DIV_RESET;
			intcnt_q <= STC_INTCNT_RESET;
			tmo_q <= STC_TMO_RESET;
			tmo_cnt_q <= '0;
			restart_q <= 1'b0;
			core_q <= 1'b0;
			full_q <= 1'b0;
			next_int_q <= '0;
			run_left_q <= '0;
			fail_int_q <= '0;
			stat_q <= '0;
			mask_q <= '0;
			rst_cnt_q <= '0;
			rdata_q <= '0;
			fail_seen_q <= 1'b0;
		end else if (clk_en_in) begin
			state_q <= state_d;
			div_q <= div_d;
			intcnt_q <= intcnt_d;
			tmo_q <= tmo_d;
			tmo_cnt_q <= tmo_cnt_d;
			restart_q <= restart_d;
			core_q <= core_d;
			full_q <= full_d;
			next_int_q <= next_int_d;
			run_left_q <= run_left_d;
			fail_int_q <= fail_int_d;
			stat_q <= stat_d;
			mask_q <= mask_d;
			rst_cnt_q <= rst_cnt_d;
			rdata_q <= rdata_d;
			fail_seen_q <= fail_seen_d;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign reg_rdata_out = rdata_q;
	assign engine_start_out = iv_start;
	assign engine_tick_out = tick && iv_busy;
	assign engine_interval_out = next_int_q;
	assign engine_core_sel_out = core_q;
	// Isolation held through the reset pulse so no glitch leaks out
	assign core_isolate_out = (state_q != STC_IDLE) ?
		(core_q ? 2'b10 : 2'b01) : 2'b00;
	assign cpu_reset_out = (state_q == STC_RESET);
	assign irq_out = |(stat_q & mask_q);
endmodule // stc_ctrl

/* stc_ctrl_chk.sv */
// Checker: port-level properties of the self-test controller
`timescale 1ns/1ps
module stc_ctrl_chk
	import stc_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic engine_start_out,
	input wire logic engine_tick_out,
	input wire logic engine_fail_in,
	input wire logic engine_core_sel_out,
	input wire logic [1:0] core_isolate_out,
	input wire logic cpu_reset_out,
	input wire logic irq_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	logic [7:0] rst_cnt_q;
	logic [7:0] rst_cnt_d;
	always_comb rst_cnt_d = cpu_reset_out ? rst_cnt_q + 8'h01 : 8'h00;
	always_ff @(posedge sys_clk_in) rst_cnt_q <= sys_rst_in ? 8'h00 : rst_cnt_d;
	rd_idle_zero_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
		else $error("read data outside read slot");
	tick_isolated_a: assert property (engine_tick_out |-> core_isolate_out[engine_core_sel_out])
		else $error("tick without isolation");
	start_isolates_a: assert property (engine_start_out |=> core_isolate_out[engine_core_sel_out])
		else $error("start without isolation");
	reset_len_a: assert property ($fell(cpu_reset_out) |-> rst_cnt_q == STC_RST_PULSE_CYC)
		else $error("reset pulse length");
	reset_release_a: assert property ($fell(cpu_reset_out) |-> core_isolate_out == 2'b00)
		else $error("isolation kept after reset");
	reset_after_run_a: assert property ($rose(cpu_reset_out) |-> $past(core_isolate_out) != 2'b00)
		else $error("reset without a run");
	reset_quiet_a: assert property (cpu_reset_out |-> !engine_tick_out && !engine_start_out)
		else $error("engine active in reset");
	isolate_hold_a: assert property (cpu_reset_out |-> core_isolate_out[engine_core_sel_out])
		else $error("isolation dropped in reset");
	cover property ($rose(cpu_reset_out));
	cover property ($rose(irq_out));
	cover property (engine_fail_in && engine_tick_out);
endmodule // stc_ctrl_chk

bind stc_ctrl stc_ctrl_chk u_stc_ctrl_chk (.sys_clk_in, .sys_rst_in, .reg_rd_in, .reg_rdata_out,
	.engine_start_out, .engine_tick_out, .engine_fail_in, .engine_core_sel_out,
	.core_isolate_out, .cpu_reset_out, .irq_out);

/* stc_engine_model.sv */
// Partner model: self-test engine checking the cores under test
`timescale 1ns/1ps
module stc_engine_model
	import stc_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic start_in,
	input wire logic tick_in,
	input wire logic [STC_INT_W-1:0] interval_in,
	input wire logic fail_en_in,
	input wire logic [STC_INT_W-1:0] fail_at_in,
	output logic fail_out,
	output logic [15:0] ticks_out
);
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in || start_in)
			ticks_out <= {15'h0, tick_in && !sys_rst_in};
		else if (tick_in)
			ticks_out <= ticks_out + 16'h1;
	end
	// Mismatch only once the bad interval has clocked patterns
	assign fail_out = fail_en_in && interval_in == fail_at_in && ticks_out != 16'h0;
endmodule // stc_engine_model

/* tb.sv */
// Testbench: register-driven self-test runs of the controller
`timescale 1ns/1ps
module tb
	import stc_pkg::*;
;
	logic sys_clk_in, sys_rst_in, reg_wr_in, reg_rd_in, fail_en, engine_fail_in;
	logic [31:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
	logic engine_start_out, engine_tick_out, engine_core_sel_out, cpu_reset_out, irq_out;
	logic [STC_INT_W-1:0] engine_interval_out;
	logic [1:0] core_isolate_out;
	logic [15:0] ticks;
	int err_count = 0;
	int tests_run = 0;
	int n;
	stc_ctrl u_stc_ctrl (.sys_clk_in, .sys_rst_in, .clk_en_in(1'b1), .reg_addr_in, .reg_wdata_in,
		.reg_wr_in, .reg_rd_in, .reg_rdata_out, .engine_start_out, .engine_tick_out,
		.engine_interval_out, .engine_core_sel_out, .engine_fail_in, .core_isolate_out,
		.cpu_reset_out, .irq_out);
	stc_engine_model u_stc_engine_model (.sys_clk_in, .sys_rst_in, .start_in(engine_start_out),
		.tick_in(engine_tick_out), .interval_in(engine_interval_out), .fail_en_in(fail_en),
		.fail_at_in(5'h01), .fail_out(engine_fail_in), .ticks_out(ticks));
	task automatic stop_test;
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string s);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s got %h", $time, s, got);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b0;
		#1;
		check(reg_rdata_out & m, e, "register read");
	endtask
	// Counts cycles from the start write until the end-of-run reset
	task automatic run(input logic [31:0] c, input int lo, input int hi);
		n = 0;
		wr(STC_CTRL_ADDR, c);
		while (cpu_reset_out !== 1'b1 && n < 9000) begin
			@(posedge sys_clk_in);
			n++;
		end
		check(32'(n >= lo && n <= hi), 32'h1, "run length");
		while (cpu_reset_out !== 1'b0) @(posedge sys_clk_in);
	endtask
	initial begin
		sys_clk_in = 1'b0;
		forever #2.5 sys_clk_in = ~sys_clk_in;
	end
	initial begin
		repeat (40000) @(posedge sys_clk_in);
		err_count++;
		$display("wrong value at %0t: watchdog", $time);
		stop_test();
	end
	initial begin
		{sys_rst_in, reg_wr_in, reg_rd_in, fail_en} = 4'h8;
		reg_addr_in = 32'h0;
		reg_wdata_in = 32'h0;
		repeat (20) @(posedge sys_clk_in);
		sys_rst_in <= 1'b0;
		rd(STC_DIVIDE_RATIO_FIELD_ADDR, 32'hffffffff, 32'h0);
		rd(STC_INTCNT_ADDR, 32'hffffffff, 32'h1);
		rd(STC_TMO_ADDR, 32'hffffffff, 32'hffffffff);
		rd(32'hffffe120, 32'hffffffff, 32'h0);
		// Setup order clocks, count, timeout; ratio 2 keeps test clock at half rate
		wr(STC_DIVIDE_RATIO_FIELD_ADDR, 32'h1);
		wr(STC_INTCNT_ADDR, 32'h1);
		wr(STC_TMO_ADDR, 32'h0000ffff);
		run(32'h1, 2730, 2745);
		check(32'(ticks), 32'd1365, "ticks");
		rd(STC_STAT_ADDR, 32'hff, 32'h21);
		rd(STC_CURINT_ADDR, 32'h1f, 32'h1);
		wr(STC_STAT_ADDR, 32'h3f);
		fail_en <= 1'b1;
		wr(STC_IMASK_ADDR, 32'h2);
		wr(STC_DIVIDE_RATIO_FIELD_ADDR, 32'h2);
		run(32'h1, 4095, 4110);
		check(32'(irq_out), 32'h1, "irq raised");
		rd(STC_FAILINT_ADDR, 32'h1f, 32'h1);
		rd(STC_STAT_ADDR, 32'h23, 32'h23);
		rd(STC_CURINT_ADDR, 32'h1f, 32'h2);
		wr(STC_STAT_ADDR, 32'h2);
		rd(STC_STAT_ADDR, 32'h2, 32'h0);
		check(32'(irq_out), 32'h0, "irq cleared");
		fail_en <= 1'b0;
		wr(STC_DIVIDE_RATIO_FIELD_ADDR, 32'h1);
		wr(STC_INTCNT_ADDR, 32'h2);
		run(32'h7, 5460, 5480);
		rd(STC_CURINT_ADDR, 32'h1f, 32'h2);
		rd(STC_STAT_ADDR, 32'h27, 32'h21);
		wr(STC_TMO_ADDR, 32'h40);
		wr(STC_INTCNT_ADDR, 32'h1);
		run(32'h1, 60, 72);
		rd(STC_STAT_ADDR, 32'h26, 32'h26);
		check(32'(irq_out), 32'h1, "timeout irq");
		wr(STC_IMASK_ADDR, 32'h0);
		rd(STC_IMASK_ADDR, 32'hff, 32'h0);
		check(32'(irq_out), 32'h0, "irq masked");
		stop_test();
	end
endmodule // tb
